/* rtl/pcibar_decode.sv */
/*
  Two configuration base address registers (I/O and memory window) and
  the address-phase decoder that claims matching accesses.
  Assumes the configuration access logic presents a decoded write/read
  strobe with the register offset, and the bus front end presents the
  address phase as a one-cycle strobe with AD and C/BE.
  Assumes the command register sits outside and hands in its two decode
  enables as levels; soft reset and the stop bit never reach this block,
  so only the hardware reset input clears the stored bases.
*/
`timescale 1ns/1ps
`include "pcibar_defines.svh"

// Functional notes
// - A 32-bit I/O window base register sits at config offset 0x10.
// - With I/O decode on, an I/O command matching on AD[31:5] is claimed.
// - The I/O base field is read/write and cleared only by hardware reset.
// - Bits 4-2 of the I/O register read zero, giving a 32-byte footprint.
// - Bit 1 of the I/O register reads zero and bit 0 reads one.
// - A 32-bit memory window base register sits at config offset 0x14.
// - Bit 4 of the memory register reads zero, giving a 32-byte window.
// - The prefetchable bit of the memory register reads zero.
// - With memory decode on, a memory cycle matching AD[31:5] is claimed.
// - Memory register bits 2-1 and bit 0 read zero and ignore writes.
// - The memory base field is cleared only by hardware reset.
module pcibar_decode (
  // Clock and hardware reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Configuration access
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic [3:0]  cfg_be,
  output logic      [31:0] cfg_rdata,
  // Command register enables
  input  wire logic        io_decode_enable,
  input  wire logic        mem_decode_enable,
  // Address phase
  input  wire logic        addr_phase,
  input  wire logic [31:0] ad,
  input  wire logic [3:0]  cbe,
  // Claim outputs
  output logic             devsel_claim,
  output logic             io_hit,
  output logic             mem_hit
);

  // Stored bases, their next values and the decode terms
  pcibar_pkg::pcibar_base_t io_window_base_r;
  pcibar_pkg::pcibar_base_t mem_window_base_r;
  pcibar_pkg::pcibar_base_t io_window_base_nxt;
  pcibar_pkg::pcibar_base_t mem_window_base_nxt;
  pcibar_pkg::pcibar_hit_e  hit_nxt;
  logic [31:0]              wmask;
  logic [31:0]              rdata_nxt;
  logic                     io_wr_sel;
  logic                     mem_wr_sel;
  logic                     io_rd_sel;
  logic                     mem_rd_sel;
  logic                     io_cmd_hit;
  logic                     mem_cmd_hit;
  logic                     io_base_match;
  logic                     mem_base_match;
  logic                     claim_nxt;
  logic                     io_hit_nxt;
  logic                     mem_hit_nxt;

  // Commands that address I/O space
  function automatic logic is_io_cmd(input logic [3:0] c);
    return (c == `PCIBAR_CMD_IO) || (c == `PCIBAR_CMD_IOWR);
  endfunction : is_io_cmd

  // Commands that address memory space
  function automatic logic is_mem_cmd(input logic [3:0] c);
    return (c == `PCIBAR_CMD_MEMRD) || (c == `PCIBAR_CMD_MEMWR) ||
           (c == `PCIBAR_CMD_MEMRDM) || (c == `PCIBAR_CMD_MEMRDL) ||
           (c == `PCIBAR_CMD_MEMWI);
  endfunction : is_mem_cmd

  // Offset decode, shared by the write and read paths
  function automatic logic is_io_ofs(input logic [7:0] a);
    return a == `PCIBAR_OFS_IO;
  endfunction : is_io_ofs

  function automatic logic is_mem_ofs(input logic [7:0] a);
    return a == `PCIBAR_OFS_MEM;
  endfunction : is_mem_ofs

  // Byte-lane merge; the low field never reaches storage
  function automatic pcibar_pkg::pcibar_base_t merge_base(
    input pcibar_pkg::pcibar_base_t old_base,
    input logic [31:0]              wdata,
    input logic [31:0]              mask
  );
    return (wdata[`PCIBAR_BASE_HI:`PCIBAR_BASE_LO] &
            mask[`PCIBAR_BASE_HI:`PCIBAR_BASE_LO]) |
           (old_base & ~mask[`PCIBAR_BASE_HI:`PCIBAR_BASE_LO]);
  endfunction : merge_base

  // Read image: stored base above its fixed low field
  function automatic logic [31:0] read_image(
    input pcibar_pkg::pcibar_base_t base,
    input logic [4:0]               low_bits
  );
    return {base, low_bits};
  endfunction : read_image

  // Byte enables widened to a bit mask, one lane per enable
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign wmask[lane*8 +: 8] = {8{cfg_be[lane]}};
  end

  // Register selects
  assign io_wr_sel  = cfg_wr && is_io_ofs(cfg_addr);
  assign mem_wr_sel = cfg_wr && is_mem_ofs(cfg_addr);
  assign io_rd_sel  = is_io_ofs(cfg_addr);
  assign mem_rd_sel = is_mem_ofs(cfg_addr);

  // Next I/O base
  always_comb begin
    io_window_base_nxt = io_window_base_r;
    if (io_wr_sel) begin
      io_window_base_nxt = merge_base(io_window_base_r, cfg_wdata,
                                      wmask);
    end
  end

  // Next memory base
  always_comb begin
    mem_window_base_nxt = mem_window_base_r;
    if (mem_wr_sel) begin
      mem_window_base_nxt = merge_base(mem_window_base_r, cfg_wdata,
                                       wmask);
    end
  end

  // I/O base; only hardware reset clears it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      io_window_base_r <= `PCIBAR_BASE_RST;
    end else begin
      io_window_base_r <= io_window_base_nxt;
    end
  end

  // Memory base; same storage rules as the I/O base
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_window_base_r <= `PCIBAR_BASE_RST;
    end else begin
      mem_window_base_r <= mem_window_base_nxt;
    end
  end

  // Read data: low field is constant, writes never reach it
  always_comb begin
    rdata_nxt = `PCIBAR_RDATA_NONE;
    if (io_rd_sel) begin
      rdata_nxt = read_image(io_window_base_r,
                             `PCIBAR_IO_LOW_BITS);
    end else if (mem_rd_sel) begin
      rdata_nxt = read_image(mem_window_base_r,
                             `PCIBAR_MEM_LOW_BITS);
    end
  end

  // Returned read word holds until the next read strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_rdata <= `PCIBAR_RDATA_RST;
    end else if (cfg_rd) begin
      cfg_rdata <= rdata_nxt;
    end
  end

  // Command class and base compare; enables assumed set after a base
  assign io_cmd_hit     = io_decode_enable && is_io_cmd(cbe);
  assign mem_cmd_hit    = mem_decode_enable && is_mem_cmd(cbe);
  assign io_base_match  = ad[`PCIBAR_BASE_HI:`PCIBAR_BASE_LO] ==
                          io_window_base_r;
  assign mem_base_match = ad[`PCIBAR_BASE_HI:`PCIBAR_BASE_LO] ==
                          mem_window_base_r;

  // I/O window checked first; a command is only ever one class
  always_comb begin
    hit_nxt = pcibar_pkg::pcibar_hit_none;
    if (addr_phase && io_cmd_hit && io_base_match) begin
      hit_nxt = pcibar_pkg::pcibar_hit_io;
    end else if (addr_phase && mem_cmd_hit && mem_base_match) begin
      hit_nxt = pcibar_pkg::pcibar_hit_mem;
    end
  end

  // All three outputs follow the one decode result
  always_comb begin
    claim_nxt   = hit_nxt != pcibar_pkg::pcibar_hit_none;
    io_hit_nxt  = hit_nxt == pcibar_pkg::pcibar_hit_io;
    mem_hit_nxt = hit_nxt == pcibar_pkg::pcibar_hit_mem;
  end

  // One-cycle claim pulse after the address phase
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      devsel_claim <= `PCIBAR_CLAIM_RST;
    end else begin
      devsel_claim <= claim_nxt;
    end
  end

  // I/O window matched, in step with the claim
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      io_hit <= `PCIBAR_CLAIM_RST;
    end else begin
      io_hit <= io_hit_nxt;
    end
  end

  // Memory window matched, in step with the claim
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_hit <= `PCIBAR_CLAIM_RST;
    end else begin
      mem_hit <= mem_hit_nxt;
    end
  end

endmodule : pcibar_decode

/* rtl/pcibar_defines.svh */
/*
  Offsets, field positions and fixed values of the two base address
  registers. Included by the design module only.
*/
`ifndef PCIBAR_DEFINES_SVH
`define PCIBAR_DEFINES_SVH
`define PCIBAR_OFS_IO       8'h10
`define PCIBAR_OFS_MEM      8'h14
`define PCIBAR_BASE_HI      31
`define PCIBAR_BASE_LO      5
`define PCIBAR_BASE_W       27
`define PCIBAR_BASE_RST     27'h0
`define PCIBAR_RDATA_RST    32'h0000_0000
`define PCIBAR_RDATA_NONE   32'h0000_0000
`define PCIBAR_CLAIM_RST    1'h0
`define PCIBAR_IO_LOW_BITS  5'h01
`define PCIBAR_MEM_LOW_BITS 5'h00
`define PCIBAR_CMD_IO       4'h2
`define PCIBAR_CMD_MEMRD    4'h6
`define PCIBAR_CMD_MEMWR    4'h7
`define PCIBAR_CMD_MEMRDM   4'hC
`define PCIBAR_CMD_MEMRDL   4'hE
`define PCIBAR_CMD_MEMWI    4'hF
`define PCIBAR_CMD_IOWR     4'h3
`endif

/* rtl/pcibar_pkg.sv */
/*
  Types for the base address decoder. Assumes pcibar_defines.svh is on
  the include path.
*/
package pcibar_pkg;
  typedef logic [26:0] pcibar_base_t;
  typedef enum logic [1:0] {
    pcibar_hit_none,
    pcibar_hit_io,
    pcibar_hit_mem
  } pcibar_hit_e;
endpackage : pcibar_pkg

/* testbench/pcibar_asserts.sv */
/* Port checker for pcibar_decode.
   Assumes a bind from the bench top. */
`timescale 1ns/1ps
module pcibar_asserts (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Configuration access
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata,
  // Enables and address phase
  input wire logic        io_decode_enable,
  input wire logic        mem_decode_enable,
  input wire logic        addr_phase,
  input wire logic [3:0]  cbe,
  // Claim outputs
  input wire logic        devsel_claim,
  input wire logic        io_hit,
  input wire logic        mem_hit
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence io_rd_s; cfg_rd && cfg_addr == 8'h10; endsequence
  sequence mem_rd_s; cfg_rd && cfg_addr == 8'h14; endsequence
  sequence io_cmd_s; addr_phase && cbe[3:1] == 3'h1; endsequence
  io_low_a:
    assert property (io_rd_s |=> cfg_rdata[4:0] == 5'h01) else $error("io low");
  mem_low_a:
    assert property (mem_rd_s |=> cfg_rdata[4:0] == 5'h00) else $error("mem low");
  other_ofs_a:
    assert property (cfg_rd && !(cfg_addr inside {8'h10, 8'h14}) |=>
      cfg_rdata == 32'h0) else $error("unmapped read");
  rd_hold_a:
    assert property (!cfg_rd |=> $stable(cfg_rdata)) else $error("rdata moved");
  idle_claim_a:
    assert property (!addr_phase |=> !devsel_claim) else $error("stray claim");
  claim_pair_a:
    assert property (devsel_claim == (io_hit || mem_hit)) else $error("pair");
  io_off_a:
    assert property (addr_phase && !(io_decode_enable && cbe[3:1] == 3'h1)
      |=> !io_hit) else $error("io hit off");
  mem_off_a:
    assert property (addr_phase && !mem_decode_enable |=> !mem_hit)
      else $error("mem hit off");
  mem_io_a:
    assert property (io_cmd_s |=> !mem_hit) else $error("mem hit on io");
endmodule : pcibar_asserts

/* testbench/pcibar_host.sv */
/* Host model: config cycles and address phases.
   Assumes one caller at a time. */
`timescale 1ns/1ps
module pcibar_host (
  // Clock
  input  wire logic   core_clk,
  // Configuration requests
  output logic        cfg_wr,
  output logic        cfg_rd,
  output logic [7:0]  cfg_addr,
  output logic [31:0] cfg_wdata,
  output logic [3:0]  cfg_be,
  // Address phase
  output logic        addr_phase,
  output logic [31:0] ad,
  output logic [3:0]  cbe
);
  initial begin
    {cfg_wr, cfg_rd, addr_phase, cfg_addr, cfg_be} = '0;
    {cbe, cfg_wdata, ad} = '0;
  end
  // One access at a time, reads never reordered
  task cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) #1;
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_be} = {w, !w, a, d, 4'hF};
    @(posedge core_clk) #1;
    {cfg_wr, cfg_rd, cfg_wdata} = {2'h0, ~d};
  endtask : cfg
  // Write with only some byte lanes enabled
  task cfg_part(input logic [7:0] a, input logic [31:0] d,
                input logic [3:0] b);
    @(posedge core_clk) #1;
    {cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {1'b1, a, d, b};
    @(posedge core_clk) #1;
    {cfg_wr, cfg_wdata, cfg_be} = {1'b0, ~d, 4'hF};
  endtask : cfg_part
  task phase(input logic [31:0] a, input logic [3:0] c);
    @(posedge core_clk) #1;
    {addr_phase, ad, cbe} = {1'b1, a, c};
    @(posedge core_clk) #1;
    {addr_phase, ad} = {1'b0, ~a};
  endtask : phase
endmodule : pcibar_host

/* testbench/testbench.sv */
/* Bench for pcibar_decode driven by the host model.
   Assumes rtl/ on the include path. */
`timescale 1ns/1ps
module testbench;
  logic        core_clk, reset, io_decode_enable, mem_decode_enable;
  logic        cfg_wr, cfg_rd, addr_phase, devsel_claim, io_hit, mem_hit;
  logic [7:0]  cfg_addr;
  logic [3:0]  cbe, cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, ad;
  logic [3:0]  mc [5] = '{4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
  int          n_fail, check_count;
  pcibar_host host_u (.core_clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
    .ad, .addr_phase, .cbe, .cfg_be);
  pcibar_decode dut_u (.core_clk, .reset, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_wdata, .cfg_be, .cfg_rdata, .io_decode_enable,
    .mem_decode_enable, .addr_phase, .ad, .cbe, .devsel_claim, .io_hit,
    .mem_hit);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host_u.cfg(1'b0, a, 32'h0);
    chk("cfg_rdata", exp, cfg_rdata);
  endtask : rd_chk
  task hit_chk(input logic [31:0] a, input logic [3:0] c, input logic [2:0] e);
    host_u.phase(a, c);
    chk("claim", {29'h0, e}, {29'h0, devsel_claim, io_hit, mem_hit});
  endtask : hit_chk
  task t_size;
    rd_chk(8'h10, 32'h0000_0001);
    rd_chk(8'h14, 32'h0);
    host_u.cfg(1'b1, 8'h10, 32'hFFFF_FFFF);
    host_u.cfg(1'b1, 8'h14, 32'hFFFF_FFFF);
    host_u.cfg(1'b1, 8'h18, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'hFFFF_FFE1);
    rd_chk(8'h14, 32'hFFFF_FFE0);
    rd_chk(8'h18, 32'h0);
  endtask : t_size
  task t_dec;
    host_u.cfg(1'b1, 8'h10, 32'hABCD_E07F);
    host_u.cfg(1'b1, 8'h14, 32'h5555_5AA7);
    rd_chk(8'h10, 32'hABCD_E061);
    hit_chk(32'hABCD_E060, 4'h2, 3'h0);
    io_decode_enable = 1'b1;
    mem_decode_enable = 1'b1;
    hit_chk(32'hABCD_E07F, 4'h2, 3'h6);
    hit_chk(32'hABCD_E060, 4'h3, 3'h6);
    hit_chk(32'hABCD_F060, 4'h2, 3'h0);
    hit_chk(32'h5555_5ABF, 4'h3, 3'h0);
    hit_chk(32'hABCD_E060, 4'h6, 3'h0);
    foreach (mc[i]) hit_chk(32'h5555_5ABF, mc[i], 3'h5);
    mem_decode_enable = 1'b0;
    hit_chk(32'h5555_5AA0, 4'h7, 3'h0);
  endtask : t_dec
  task t_rst;
    reset = 1'b1;
    @(posedge core_clk) #1;
    reset = 1'b0;
    rd_chk(8'h10, 32'h0000_0001);
    rd_chk(8'h14, 32'h0);
  endtask : t_rst
  task t_lane;
    host_u.cfg_part(8'h10, 32'hFFFF_FFFF, 4'h4);
    host_u.cfg_part(8'h14, 32'h1234_5678, 4'h9);
    rd_chk(8'h10, 32'h00FF_0001);
    rd_chk(8'h14, 32'h1200_0060);
  endtask : t_lane
  task stop_test;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial begin
    {reset, io_decode_enable, mem_decode_enable} = 3'h4;
    n_fail = 0;
    check_count = 0;
    repeat (10) @(posedge core_clk);
    #1 reset = 1'b0;
    t_size;
    t_dec;
    t_rst;
    t_lane;
    stop_test;
  end
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end
endmodule : testbench
bind pcibar_decode pcibar_asserts chk_u (.core_clk, .reset, .cfg_rd,
  .addr_phase, .io_decode_enable, .mem_decode_enable, .devsel_claim,
  .io_hit, .mem_hit, .cfg_addr, .cbe, .cfg_rdata);
